// [src/flash_cfg_pkg.sv]
// Behaviour
// R1: Parallel flash mode fetches the bitstream with plain asynchronous reads by default.
// R2: Reads start at a start address, zero after reset, reloadable for image select.
// R3: Flash bus width, eight or sixteen bits, is detected automatically.
// R4: With an eight-bit flash only the low data byte is captured.
// R5: Mode pins are sampled when the init status line rises, then mode chosen.
// R6: In parallel flash mode write enable high, output enable and chip select low.
// R7: Address changes after a clock edge; data is sampled on the next edge.
// R8: Address counter starts at the start address and steps by one per word.
// R9: Counter at maximum before done sets wraparound error and starts fallback.
// R10: Page reads give the first page word a long access, later words short.
// R11: Every page word except the first is read in a single clock cycle; the code holds the address longer while space_ok is low.
// R12: Words per page come from a page-size setting loaded from the bitstream.
// R13: First word of a page gets the loaded first-read cycle count.
// R14: Page timing follows loaded control values, not a fixed schedule.
// R15: After reset page size one, first access one cycle, slowest clock.
// R16: New page timing written to the option register applies at the next page boundary.
// R17: A bitstream command switches the configuration clock to the user frequency.
// R18: Address-valid strobe and flash clock are not used for asynchronous reads.
// R19: Two revision-select outputs are offered for multi-image configuration.
// R20: A chain select output drives the next device in a daisy chain.
// R21: In eight-bit mode the lowest address bit selects the byte.
// R22: Page size accepts only one, four or eight words.
// R23: In basic mode each address stands exactly one clock cycle; the code holds it longer while space_ok is low (word FIFO near full).
package flash_cfg_pkg;
    // ==========================================================
    // Widths and limits
    localparam int          ADDR_W       = 29;
    localparam int          DATA_W       = 16;
    localparam int          FIFO_DEPTH   = 8;
    localparam int          FIFO_SLACK   = 3;
    localparam logic [28:0] ADDR_MAX     = 29'h1FFFFFF;
    localparam logic [28:0] START_RST    = 29'h0000000;
    localparam logic [2:0]  MODE_PAR     = 3'h2;
    localparam logic [7:0]  X8_UPPER     = 8'hFF;
    localparam logic [1:0]  REV_RST      = 2'h0;

    // ==========================================================
    // Page-read option field encodings and reset values
    localparam logic [1:0]  PAGE_ENC_1   = 2'h0;
    localparam logic [1:0]  PAGE_ENC_4   = 2'h1;
    localparam logic [1:0]  PAGE_ENC_8   = 2'h2;
    localparam logic [1:0]  PAGE_ENC_BAD = 2'h3;
    localparam logic [1:0]  PAGE_RST     = PAGE_ENC_1;
    localparam logic [3:0]  FIRST_RST    = 4'h1;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [1:0] page_enc;
        logic [3:0] first_cycles;
    } page_cfg_t;

    typedef struct packed {
        logic [15:0] data;
        logic        byte_mode;
    } flash_word_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_READ  = 4'h2,
        ST_DONE  = 4'h4,
        ST_ERROR = 4'h8
    } load_state_t;
endpackage

// [src/word_fifo.sv]
`timescale 1ns/1ns
// ==========================================================
// Small synchronous FIFO with valid/ready on both sides
module word_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire logic [WIDTH-1:0]         in_data,
    input  wire logic                     in_valid,
    output logic                          in_ready,
    output logic [WIDTH-1:0]              out_data,
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [$clog2(DEPTH+1)-1:0]    count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0]         mem_ff [DEPTH];
    logic [AW-1:0]            wr_ff;
    logic [AW-1:0]            rd_ff;
    logic [$clog2(DEPTH+1)-1:0] cnt_ff;
    logic                     push;
    logic                     pop;

    // Honest flags straight from the occupancy count
    assign in_ready  = (cnt_ff != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign out_valid = (cnt_ff != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_ff[rd_ff];
    assign count     = cnt_ff;

    // Storage needs no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    // Pointers wrap because depth is a power of two
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= rd_ff + 1'b1;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule

// [src/flash_cfg_reader.sv]
`timescale 1ns/1ns
// ==========================================================
// Parallel NOR asynchronous configuration reader
module flash_cfg_reader (
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic                        init_status,
    input  wire logic [2:0]                  mode_select,
    input  wire logic                        config_done,
    input  wire logic [15:0]                 flash_data,
    output logic [flash_cfg_pkg::ADDR_W-1:0] flash_addr,
    output logic                             flash_write_en_n,
    output logic                             flash_output_en_n,
    output logic                             flash_chip_sel_n,
    input  wire logic                        start_addr_load,
    input  wire logic [flash_cfg_pkg::ADDR_W-1:0] start_addr,
    input  wire logic                        config_option_reg_wr,
    input  wire flash_cfg_pkg::page_cfg_t    config_option_reg,
    input  wire logic                        clk_switch_cmd,
    output logic                             user_clk_sel,
    input  wire logic [1:0]                  revision_select_in,
    output logic [1:0]                       revision_select,
    output logic                             chain_select_out_n,
    output logic                             wrap_error,
    output logic                             fallback_start,
    output logic                             bus_x8,
    output flash_cfg_pkg::flash_word_t       word_data,
    output logic                             word_valid,
    input  wire logic                        word_ready
);
    import flash_cfg_pkg::*;

    load_state_t        state_ff;
    logic               init_meta_ff, init_sync_ff, init_prev_ff;
    logic [2:0]         mode_meta_ff, mode_sync_ff;
    logic               done_meta_ff, done_sync_ff;
    logic [15:0]        data_meta_ff, data_sync_ff;
    logic [ADDR_W-1:0]  addr_ff;
    logic [ADDR_W-1:0]  start_ff;
    logic [3:0]         hold_ff;
    logic [2:0]         page_idx_ff;
    page_cfg_t          active_ff;
    page_cfg_t          pending_ff;
    logic [1:0]         tag_ff;
    logic               first_word_ff;
    logic               x8_ff;
    logic               wrap_ff;
    logic               fallback_ff;
    logic               user_clk_ff;
    logic [1:0]         rev_ff;
    logic               chain_ff;
    logic               init_rise;
    logic               space_ok;
    logic               advance;
    logic               at_max;
    logic               boundary;
    logic [2:0]         nxt_page_idx;
    logic [3:0]         nxt_hold;
    logic               fifo_ready;
    logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_count;
    flash_word_t        push_word;

    // Words per page for an encoding; illegal codes never reach here
    function automatic logic [3:0] page_words(input logic [1:0] enc);
        unique case (enc)
            PAGE_ENC_4: page_words = 4'h4;
            PAGE_ENC_8: page_words = 4'h8;
            default:    page_words = 4'h1;
        endcase
    endfunction

    // A zero first-read count would wrap the hold counter to sixteen cycles, so treat it as one
    function automatic logic [3:0] first_len(input logic [3:0] c);
        first_len = (c == 4'h0) ? 4'h1 : c;
    endfunction

    // ==========================================================
    // Pin synchronisers; first stage is read only by the second
    always_ff @(posedge clk) begin
        init_meta_ff <= init_status;
        init_sync_ff <= init_meta_ff;
        mode_meta_ff <= mode_select;
        mode_sync_ff <= mode_meta_ff;
        done_meta_ff <= config_done;
        done_sync_ff <= done_meta_ff;
        data_meta_ff <= flash_data;   // Sampling edge for the presented address
        data_sync_ff <= data_meta_ff;
    end

    // Edge history for the init release
    always_ff @(posedge clk) begin
        if (srst) begin
            init_prev_ff <= 1'b0;
        end else begin
            init_prev_ff <= init_sync_ff;
        end
    end

    assign init_rise = init_sync_ff & ~init_prev_ff;
    // Keep room for words already in flight in the sync pipeline
    assign space_ok  = (fifo_count <= FIFO_DEPTH[$clog2(FIFO_DEPTH+1)-1:0]
                        - FIFO_SLACK[$clog2(FIFO_DEPTH+1)-1:0]);
    assign advance   = (state_ff == ST_READ) && !done_sync_ff
                       && (hold_ff == 4'h1) && space_ok;
    assign at_max    = (addr_ff == ADDR_MAX);
    assign nxt_page_idx = ((4'(page_idx_ff) + 4'h1) >= page_words(active_ff.page_enc))
                          ? 3'h0 : page_idx_ff + 3'h1;
    assign boundary  = (nxt_page_idx == 3'h0);
    assign nxt_hold  = boundary ? first_len(pending_ff.first_cycles) : 4'h1; // see R11

    // ==========================================================
    // Load sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (init_rise && mode_sync_ff == MODE_PAR) begin // see R5
                        state_ff <= ST_READ;                         // see R1
                    end
                end
                ST_READ: begin
                    if (done_sync_ff) begin
                        state_ff <= ST_DONE;
                    end else if (advance && at_max) begin
                        state_ff <= ST_ERROR;
                    end
                end
                ST_DONE:  state_ff <= ST_DONE;
                ST_ERROR: state_ff <= ST_ERROR;
            endcase
        end
    end

    // Start address, reloadable by the image selector
    always_ff @(posedge clk) begin
        if (srst) begin
            start_ff <= START_RST;
        end else if (start_addr_load) begin
            start_ff <= start_addr;                 // see R2
        end
    end

    // ==========================================================
    // Address counter and per-word access time
    always_ff @(posedge clk) begin
        if (srst) begin
            addr_ff     <= START_RST;
            hold_ff     <= FIRST_RST;
            page_idx_ff <= 3'h0;
            active_ff   <= '{page_enc: PAGE_RST, first_cycles: FIRST_RST};
        end else if (state_ff == ST_IDLE) begin
            addr_ff     <= start_ff;                // see R2
            page_idx_ff <= 3'h0;
            hold_ff     <= first_len(active_ff.first_cycles); // see R13
        end else if (state_ff == ST_READ) begin
            if (advance && !at_max) begin
                addr_ff     <= addr_ff + 29'h1;     // see R8, R21
                page_idx_ff <= nxt_page_idx;
                hold_ff     <= nxt_hold;            // see R10, R23
                if (boundary) begin
                    active_ff <= pending_ff;        // see R16, R14
                end
            end else if (hold_ff != 4'h1) begin
                hold_ff <= hold_ff - 4'h1;          // see R13
            end
        end
    end

    // Option register copy; illegal page sizes are dropped whole
    always_ff @(posedge clk) begin
        if (srst) begin
            pending_ff <= '{page_enc: PAGE_RST, first_cycles: FIRST_RST}; // see R15
        end else if (config_option_reg_wr
                     && config_option_reg.page_enc != PAGE_ENC_BAD) begin // see R22
            pending_ff <= config_option_reg;        // see R12
        end
    end

    // ==========================================================
    // Capture pipeline: tag follows data through the two sync stages
    always_ff @(posedge clk) begin
        if (srst) begin
            tag_ff <= 2'h0;
        end else begin
            tag_ff <= {tag_ff[0], advance};         // see R7
        end
    end

    // Width detection from the first word; pulled-up upper lanes mean x8
    always_ff @(posedge clk) begin
        if (srst) begin
            first_word_ff <= 1'b1;
            x8_ff         <= 1'b0;
        end else if (tag_ff[1] && first_word_ff) begin
            first_word_ff <= 1'b0;
            x8_ff         <= (data_sync_ff[15:8] == X8_UPPER); // see R3
        end
    end

    always_comb begin
        push_word.byte_mode = first_word_ff ? (data_sync_ff[15:8] == X8_UPPER) : x8_ff;
        push_word.data      = push_word.byte_mode ? {8'h00, data_sync_ff[7:0]} // see R4
                                                  : data_sync_ff;
    end

    word_fifo #(
        .WIDTH ($bits(flash_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_data   (push_word),
        .in_valid  (tag_ff[1]),
        .in_ready  (fifo_ready),
        .out_data  (word_data),
        .out_valid (word_valid),
        .out_ready (word_ready),
        .count     (fifo_count)
    );

    // ==========================================================
    // Status, clock select, revision and chain outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            wrap_ff     <= 1'b0;
            fallback_ff <= 1'b0;
        end else begin
            fallback_ff <= advance && at_max;       // see R9
            if (advance && at_max) begin
                wrap_ff <= 1'b1;                    // see R9
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            user_clk_ff <= 1'b0;                    // see R15
        end else if (clk_switch_cmd) begin
            user_clk_ff <= 1'b1;                    // see R17
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rev_ff   <= REV_RST;
            chain_ff <= 1'b1;
        end else begin
            rev_ff   <= revision_select_in;         // see R19
            chain_ff <= (state_ff != ST_DONE);      // see R20
        end
    end

    // Flash strobes; no address-valid strobe or flash clock is needed
    assign flash_write_en_n   = 1'b1;                          // see R6, R18
    assign flash_output_en_n  = (state_ff != ST_READ);         // see R6
    assign flash_chip_sel_n   = (state_ff != ST_READ);         // see R6
    assign flash_addr         = addr_ff;
    assign user_clk_sel       = user_clk_ff;
    assign revision_select    = rev_ff;
    assign chain_select_out_n = chain_ff;
    assign wrap_error         = wrap_ff;
    assign fallback_start     = fallback_ff;
    assign bus_x8             = x8_ff;

    // ==========================================================
    // Checks
    chk_ctrl_read: assert property (@(posedge clk) disable iff (srst) // see R6
        state_ff == ST_READ |-> flash_write_en_n && !flash_output_en_n && !flash_chip_sel_n)
        else $error("flash strobes wrong while reading");
    chk_mode_gate: assert property (@(posedge clk) disable iff (srst) // see R5
        state_ff == ST_IDLE && init_rise && mode_sync_ff != MODE_PAR |=> state_ff == ST_IDLE)
        else $error("read began without parallel mode");
    chk_start_addr: assert property (@(posedge clk) disable iff (srst) // see R2
        state_ff == ST_IDLE && init_rise && mode_sync_ff == MODE_PAR
        |=> addr_ff == $past(start_ff))
        else $error("read did not begin at start address");
    chk_addr_step: assert property (@(posedge clk) disable iff (srst) // see R8
        advance && !at_max |=> addr_ff == $past(addr_ff) + 29'h1)
        else $error("address did not step by one");
    chk_wrap_flag: assert property (@(posedge clk) disable iff (srst) // see R9
        advance && at_max |=> wrap_error && fallback_start ##1 !fallback_start)
        else $error("wraparound not flagged");
    chk_page_inner: assert property (@(posedge clk) disable iff (srst) // see R11
        advance && !at_max && !boundary |=> hold_ff == 4'h1)
        else $error("inner page word not single cycle");
    chk_page_first: assert property (@(posedge clk) disable iff (srst) // see R13
        advance && !at_max && boundary |=> hold_ff == first_len($past(pending_ff.first_cycles)))
        else $error("first page word has wrong length");
    chk_reset_dflt: assert property (@(posedge clk) // see R15
        srst |=> active_ff.page_enc == PAGE_RST
                 && active_ff.first_cycles == FIRST_RST && !user_clk_sel)
        else $error("reset defaults wrong");
    chk_byte_lane: assert property (@(posedge clk) disable iff (srst) // see R4
        tag_ff[1] && push_word.byte_mode |-> push_word.data[15:8] == 8'h00)
        else $error("upper lane used in byte mode");
    chk_capture_lag: assert property (@(posedge clk) disable iff (srst) // see R7
        advance |-> ##2 tag_ff[1])
        else $error("capture not two edges after sample");
    chk_size_legal: assert property (@(posedge clk) disable iff (srst) // see R22
        config_option_reg_wr && config_option_reg.page_enc == PAGE_ENC_BAD
        |=> pending_ff == $past(pending_ff))
        else $error("illegal page size accepted");
    chk_clk_switch: assert property (@(posedge clk) disable iff (srst) // see R17
        clk_switch_cmd |=> user_clk_sel [*2])
        else $error("clock switch not taken");

    cov_read: cover property (@(posedge clk) disable iff (srst)
        state_ff == ST_IDLE ##1 state_ff == ST_READ);
    cov_wrap: cover property (@(posedge clk) disable iff (srst) state_ff == ST_ERROR);
    cov_x8: cover property (@(posedge clk) disable iff (srst) $rose(x8_ff));
    cov_page4: cover property (@(posedge clk) disable iff (srst)
        advance && boundary && pending_ff.page_enc == PAGE_ENC_4);
endmodule

// [test/flash_nor_model.sv]
`timescale 1ns/1ns
// ==========================================================
// Parallel NOR flash, asynchronous reads, contents derived from address
module flash_nor_model (
    input  wire logic        byte_wide,
    input  wire logic [28:0] flash_addr,
    input  wire logic        flash_output_en_n,
    input  wire logic        flash_chip_sel_n,
    output logic [15:0]      flash_data
);
    // Released bus sits at the pull-up level; strobe and clock pins are not needed
    always_comb begin
        if (flash_chip_sel_n || flash_output_en_n) begin
            flash_data = 16'hFFFF;
        end else if (byte_wide) begin
            flash_data = {8'hFF, flash_addr[7:0] ^ 8'h3C};
        end else begin
            flash_data = {flash_addr[7:0] ^ 8'h5A, flash_addr[7:0]};
        end
    end
endmodule

// [test/tb.sv]
`timescale 1ns/1ns
// ==========================================================
// Bench for the parallel flash configuration reader
module tb;
    import flash_cfg_pkg::*;
    logic              clk = 1'b0;
    logic              srst = 1'b1;
    logic              init_status = 1'b0;
    logic              config_done = 1'b0;
    logic              start_addr_load = 1'b0;
    logic              config_option_reg_wr = 1'b0;
    logic              clk_switch_cmd = 1'b0;
    logic              word_ready = 1'b0;
    logic              byte_wide = 1'b0;
    logic [2:0]        mode_select = 3'h0;
    logic [1:0]        revision_select_in = 2'h0;
    logic [ADDR_W-1:0] start_addr = START_RST;
    page_cfg_t         config_option_reg = '0;
    logic [15:0]       flash_data;
    logic [ADDR_W-1:0] flash_addr;
    logic [ADDR_W-1:0] exp_addr;
    logic [1:0]        revision_select;
    logic              flash_write_en_n, flash_output_en_n, flash_chip_sel_n;
    logic              user_clk_sel, chain_select_out_n, wrap_error;
    logic              fallback_start, bus_x8, word_valid;
    flash_word_t       word_data;
    int                miscompares = 0;
    int                compares = 0;
    int                cycles = 0;
    int                fb_cnt = 0;

    always #20 clk = ~clk;

    flash_cfg_reader dut_u (.clk(clk), .srst(srst), .init_status(init_status),
        .mode_select(mode_select), .config_done(config_done), .flash_data(flash_data),
        .flash_addr(flash_addr), .flash_write_en_n(flash_write_en_n),
        .flash_output_en_n(flash_output_en_n), .flash_chip_sel_n(flash_chip_sel_n),
        .start_addr_load(start_addr_load), .start_addr(start_addr),
        .config_option_reg_wr(config_option_reg_wr), .config_option_reg(config_option_reg),
        .clk_switch_cmd(clk_switch_cmd), .user_clk_sel(user_clk_sel),
        .revision_select_in(revision_select_in), .revision_select(revision_select),
        .chain_select_out_n(chain_select_out_n), .wrap_error(wrap_error),
        .fallback_start(fallback_start), .bus_x8(bus_x8), .word_data(word_data),
        .word_valid(word_valid), .word_ready(word_ready));

    flash_nor_model flash_u (.byte_wide(byte_wide), .flash_addr(flash_addr),
        .flash_output_en_n(flash_output_en_n), .flash_chip_sel_n(flash_chip_sel_n),
        .flash_data(flash_data));

    // ==========================================================
    // Reporting
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task final_report;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report;
        end
    end

    // Every popped word must be the next address; #1 lets falling-edge drives land
    always @(negedge clk) begin
        #1;
        if (fallback_start === 1'b1) fb_cnt++;
        if (word_valid === 1'b1 && word_ready) begin
            chk(word_data, byte_wide ? {8'h00, exp_addr[7:0] ^ 8'h3C, 1'b1}
                                     : {exp_addr[7:0] ^ 8'h5A, exp_addr[7:0], 1'b0});
            exp_addr++;
        end
    end

    // ==========================================================
    // Access tasks
    task do_reset;
        @(negedge clk);
        srst = 1'b1;
        init_status = 1'b0;
        config_done = 1'b0;
        mode_select = 3'h0;
        repeat (12) @(negedge clk);
        srst = 1'b0;
    endtask

    // Optional start address, then release init with the given mode
    task begin_read(input logic [2:0] mode, input logic x8, input logic [ADDR_W-1:0] s);
        byte_wide = x8;
        exp_addr = s;
        if (s !== START_RST) begin
            start_addr = s;
            start_addr_load = 1'b1;
            @(negedge clk);
            start_addr_load = 1'b0;
        end
        mode_select = mode;
        init_status = 1'b1;
        repeat (8) @(negedge clk);
    endtask

    task opt(input logic [1:0] enc, input logic [3:0] first);
        config_option_reg = {enc, first};
        config_option_reg_wr = 1'b1;
        @(negedge clk);
        config_option_reg_wr = 1'b0;
    endtask

    // Cycles the current address stands
    task hold(output int cnt);
        logic [ADDR_W-1:0] a;
        a = flash_addr;
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
        end while (flash_addr === a && cnt < 30);
    endtask

    // Align to a page start, then check eight holds against the page pattern
    task holds(input int first, input int period);
        int cnt;
        int k;
        hold(cnt);
        k = 0;
        while (first != 1 && cnt != first && k < 20) begin
            hold(cnt);
            k++;
        end
        for (k = 1; k <= 8; k++) begin
            hold(cnt);
            chk(cnt, (k % period == 0) ? first : 1);
        end
    endtask

    // ==========================================================
    // Scenarios
    initial begin
        do_reset;
        chk({flash_write_en_n, flash_output_en_n, flash_chip_sel_n}, 3'h7);
        chk(chain_select_out_n, 1'b1);
        chk(flash_addr, START_RST);
        chk({wrap_error, fallback_start, bus_x8, word_valid, user_clk_sel}, 5'h00);
        begin_read(3'h3, 1'b0, START_RST);
        chk(flash_chip_sel_n, 1'b1);
        do_reset;
        begin_read(MODE_PAR, 1'b0, START_RST);
        chk({flash_write_en_n, flash_output_en_n, flash_chip_sel_n}, 3'h4);
        word_ready = 1'b1;
        holds(1, 1);
        chk(bus_x8, 1'b0);
        word_ready = 1'b0;
        repeat (30) @(negedge clk);
        start_addr = flash_addr;
        repeat (5) @(negedge clk);
        chk(flash_addr, start_addr);
        word_ready = 1'b1;
        revision_select_in = 2'h3;
        clk_switch_cmd = 1'b1;
        @(negedge clk);
        clk_switch_cmd = 1'b0;
        @(negedge clk);
        chk({revision_select, user_clk_sel}, 3'h7);
        config_done = 1'b1;
        repeat (8) @(negedge clk);
        chk({flash_output_en_n, flash_chip_sel_n, chain_select_out_n}, 3'h6);
        do_reset;
        begin_read(MODE_PAR, 1'b0, START_RST);
        word_ready = 1'b1;
        opt(PAGE_ENC_4, 4'h3);
        holds(3, 4);
        opt(PAGE_ENC_BAD, 4'h5);
        holds(3, 4);
        opt(PAGE_ENC_8, 4'h2);
        holds(2, 8);
        opt(PAGE_ENC_1, 4'h0);
        holds(1, 1);
        do_reset;
        begin_read(MODE_PAR, 1'b1, 29'h0000100);
        word_ready = 1'b1;
        repeat (20) @(negedge clk);
        chk(bus_x8, 1'b1);
        do_reset;
        fb_cnt = 0;
        begin_read(MODE_PAR, 1'b0, ADDR_MAX - 29'h3);
        word_ready = 1'b1;
        repeat (20) @(negedge clk);
        chk({wrap_error, flash_chip_sel_n}, 2'h3);
        chk(fb_cnt, 1);
        chk(flash_addr, ADDR_MAX);
        final_report;
    end
endmodule
